// ---- hw/icc_pkg.sv ----
// Purpose: Shared constants and helpers for the 3x3 image convolver cascade and control block
// Assumes: Avalon-MM word registers; register index = 3-bit load address, byte address = 4*index
// Notes:   All offsets, field positions, reset values and counts live here
package icc_pkg;

    // Register indexes (byte address is four times the index)
    localparam logic [3:0] ICC_IDX_ROWLEN = 4'h0;  // Row length register
    localparam logic [3:0] ICC_IDX_ALU    = 4'h1;  // ALU microcode, accepted and discarded
    localparam logic [3:0] ICC_IDX_COEF0  = 4'h2;  // Load first coefficient bank
    localparam logic [3:0] ICC_IDX_COEF1  = 4'h3;  // Load second coefficient bank
    localparam logic [3:0] ICC_IDX_SETUP  = 4'h4;  // Setup register
    localparam logic [3:0] ICC_IDX_SEL0   = 4'h5;  // Select first bank
    localparam logic [3:0] ICC_IDX_SEL1   = 4'h6;  // Select second bank
    localparam logic [3:0] ICC_IDX_NOP    = 4'h7;  // No operation
    localparam logic [3:0] ICC_IDX_STATUS = 4'h8;  // Status, read only
    localparam int         ICC_ADDR_W     = 6;     // Byte address width of the slave

    // Setup register field positions
    localparam int ICC_SETUP_W     = 9;  // Setup register width
    localparam int ICC_SET_CASC    = 0;  // Cascade mode bit
    localparam int ICC_SET_DLY     = 1;  // Input delay field, two bits
    localparam int ICC_SET_DFMT    = 3;  // Pixel format, 1 = two's complement
    localparam int ICC_SET_CFMT    = 4;  // Coefficient format, 1 = two's complement
    localparam int ICC_SET_RND     = 5;  // Rounding field, two bits
    localparam int ICC_SET_SHIFT   = 7;  // Cascade shift field, two bits

    // Status register field positions
    localparam int ICC_ST_CPTR     = 0;  // Coefficient load pointer, four bits
    localparam int ICC_ST_BANK     = 4;  // Active bank
    localparam int ICC_ST_WINDOW   = 5;  // Row length load window still open
    localparam int ICC_ST_LOADED   = 6;  // Row length already loaded since reset

    // Reset values
    localparam logic [8:0] ICC_SETUP_RST  = 9'h000;  // Internal buffers, no delay, unsigned
    localparam logic [9:0] ICC_ROWLEN_RST = 10'h000; // Zero means 1024

    // Counts
    localparam logic [10:0] ICC_MAX_ROW     = 11'h400; // Row length meant by zero
    localparam logic [10:0] ICC_LOAD_WINDOW = 11'h400; // Cycles after reset to load row length
    localparam logic [11:0] ICC_FILL_MAX    = 12'h800; // Fill count saturation, two rows
    localparam logic [3:0]  ICC_NUM_TAPS    = 4'h9;    // Coefficients per bank
    localparam int          ICC_MEM_DEPTH   = 1024;    // Row buffer depth
    localparam int          ICC_MEM_AW      = 10;      // Row buffer address width

    // Rounding modes
    localparam logic [1:0] ICC_RND_NONE = 2'b00;  // Full 20 bits
    localparam logic [1:0] ICC_RND_16   = 2'b01;  // Round to upper 16 bits
    localparam logic [1:0] ICC_RND_8    = 2'b10;  // Round to upper 8 bits

    // Extend an 8-bit value to 9 signed bits per its format bit
    function automatic logic signed [8:0] icc_ext9(input logic [7:0] v, input logic sgn);
        return sgn ? $signed({v[7], v}) : $signed({1'b0, v});
    endfunction

    // Decode the cascade shift field into a shifted word
    function automatic logic [23:0] icc_casc_shift(input logic [15:0] v, input logic [1:0] s);
        logic [23:0] r;
        unique case (s)
            2'b00: r = {8'h00, v};
            2'b01: r = {6'h00, v, 2'b00};
            2'b10: r = {4'h0, v, 4'h0};
            2'b11: r = {v, 8'h00};
        endcase
        return r;
    endfunction

endpackage

// ---- hw/icc_line_mem.sv ----
// Purpose: Row buffer storage, 1024 words of two packed pixels
// Assumes: One write and one read port on clk; read-first on a shared address
// Notes:   Read data come out of a register one edge after the address
`timescale 1ns/1ps
module icc_line_mem
    import icc_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   nrst,
    // Write port
    input  wire logic                   we,
    input  wire logic [ICC_MEM_AW-1:0]  waddr,
    input  wire logic [15:0]            wdata,
    // Read port
    input  wire logic [ICC_MEM_AW-1:0]  raddr,
    output logic      [15:0]            rdata
);
    // Storage array, no reset so it maps onto block memory
    logic [15:0] mem [ICC_MEM_DEPTH];

    // Write port
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read; old contents are returned when the write hits the same word
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule

// ---- hw/icc_convolver.sv ----
// Purpose: 3x3 convolver core with cascade input/output, hold, reset, frame clear
// Assumes: Pixel source, cascade source and hold run on clk; host uses Avalon-MM
// Notes:   One pixel per clock unless hold suppresses the following cycle
//
// Overview of operation
// (R01) Cascade bit zero: add cascade word to result
// (R02) Cascade bit one: cascade halves feed upper rows
// (R03) Cascade word shifted left by setup bits 8:7
// (R04) Shift codes: none, two, four, eight
// (R05) Shifted cascade word summed into 20-bit result
// (R06) Offset user clears cascade bit, holds word stable
// (R07) Delayed pixel output is pixel delayed two rows
// (R08) Hold sampled each edge, freezes next cycle
// (R09) Under hold, pixels ignored and state kept
// (R10) Async reset clears everything, outputs low
// (R11) Reset defaults: internal buffers, 1024, no options
// (R12) Reset clears both banks, selects first
// (R13) Row length writable only 1024 cycles after reset
// (R14) Host resets before loading a new row length
// (R15) Row length zero means 1024, else direct
// (R16) Frame clear empties buffers, latches, result only
// (R17) Frame clear holds state, resumes after release
// (R18) Source sends pixels raster order, upper left first
// (R19) Nine products: ABC top, DEF middle, GHI bottom
// (R20) Host loads nine coefficients A to I
// (R21) Host switches bank with a clocked write
// (R22) Address codes: 0 row length, 4 setup, 5/6 select
// (R23) Row length three, cascade off: nine-tap filter
// (R24) In that mode A weights n-8, I weights n
// (R25) Setup changes take effect at any time
// (R26) Load window counts from reset only, not frame
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module icc_convolver
    import icc_pkg::*;
(
    // Clock and resets
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   frame_n,
    // Pixel stream and hold
    input  wire logic [7:0]             pixel_in,
    input  wire logic                   hold,
    // Cascade port
    input  wire logic [15:0]            cascade_in,
    output logic      [7:0]             delayed_pixel_out,
    // Result
    output logic      [19:0]            result_out,
    // Avalon-MM slave
    input  wire logic [ICC_ADDR_W-1:0]  avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic      [31:0]            avs_readdata,
    output logic                        avs_waitrequest
);
    // Control state, kept across frame clear
    typedef struct packed {
        logic [9:0]            row_len;   // Programmed row length, zero means 1024
        logic                  row_lock;  // Row length already loaded since reset
        logic [10:0]           win_cnt;   // Cycles since reset release, saturating
        logic [8:0]            setup;     // Setup register
        logic                  bank_sel;  // Active coefficient bank
        logic [3:0]            cptr;      // Next coefficient to load, A = 0
        logic [1:0][8:0][7:0]  coef;      // Two banks of nine coefficients
        logic                  hold_q;    // Sampled hold
        logic                  ack;       // Bus answer cycle
        logic [31:0]           rdata;     // Registered read data
    } icc_ctrl_s;

    // Datapath state, cleared by frame clear as well
    typedef struct packed {
        logic [2:0][7:0]       dly;       // Input delay registers
        logic [9:0]            ptr;       // Row buffer position
        logic [11:0]           fill;      // Pixels accepted since clear, saturating
        logic [2:0][2:0][7:0]  win;       // Multiplier input latches [row][age]
        logic [19:0]           result;    // Result register
    } icc_dp_s;

    icc_ctrl_s c_q;  // Control registers
    icc_ctrl_s c_d;  // Control next value
    icc_dp_s   d_q;  // Datapath registers
    icc_dp_s   d_d;  // Datapath next value

    logic        dp_rst_n;    // Either reset clears the datapath
    logic [15:0] mem_rdata;   // Row buffer read word {row2, row1}
    logic [15:0] mem_wdata;   // Row buffer write word
    logic        run;         // Datapath advances this cycle
    logic [10:0] row_eff;     // Effective row length 1..1024
    logic [11:0] row_eff2;    // Two rows
    logic [7:0]  row1;        // Pixel one row back, zero while unfilled
    logic [7:0]  row2;        // Pixel two rows back, zero while unfilled
    logic [7:0]  bot_px;      // Bottom row pixel after input delay
    logic [3:0]  bus_idx;     // Word index of the bus address
    logic        wr_fire;     // Write takes effect this edge
    logic        wr_lane;     // Low byte lane enabled
    logic signed [23:0] acc;  // Sum of products
    logic [23:0] casc_sh;     // Shifted cascade word
    logic [23:0] total;       // Sum plus cascade
    logic [23:0] rounded;     // After rounding

    assign dp_rst_n = nrst & frame_n; // R16

    // Row buffer memory; the read address runs one step ahead so data line up with ptr
    icc_line_mem u_mem (
        .clk   (clk),
        .nrst  (nrst),
        .we    (run),
        .waddr (d_q.ptr),
        .wdata (mem_wdata),
        .raddr (d_d.ptr),
        .rdata (mem_rdata)
    );

    // Bus decode and answer timing: every request waits exactly one cycle
    assign bus_idx         = avs_address[5:2];
    assign avs_waitrequest = (avs_read | avs_write) & ~c_q.ack;
    assign wr_fire         = avs_write & c_q.ack;
    assign wr_lane         = avs_byteenable[0];
    assign avs_readdata    = c_q.rdata;

    // Row geometry
    always_comb begin
        row_eff  = (c_q.row_len == 10'h000) ? ICC_MAX_ROW : {1'b0, c_q.row_len}; // R15
        row_eff2 = {row_eff, 1'b0};
        run      = ~c_q.hold_q; // R08
        // Buffered rows read as zero until that much of the frame has arrived
        row1 = (d_q.fill >= {1'b0, row_eff}) ? mem_rdata[7:0] : 8'h00; // R16
        row2 = (d_q.fill >= row_eff2) ? mem_rdata[15:8] : 8'h00;
        unique case (c_q.setup[ICC_SET_DLY +: 2])
            2'b00: bot_px = pixel_in;
            2'b01: bot_px = d_q.dly[0];
            2'b10: bot_px = d_q.dly[1];
            2'b11: bot_px = d_q.dly[2];
        endcase
        mem_wdata = {row1, bot_px}; // R07
    end

    assign delayed_pixel_out = row2; // R07

    // Sum of nine products from the latches and the active bank
    always_comb begin
        logic signed [8:0]  px;
        logic signed [8:0]  cf;
        logic signed [17:0] prod;
        px   = 9'sh000;
        cf   = 9'sh000;
        prod = 18'sh00000;
        acc = 24'sh000000;
        for (int k = 0; k < 9; k++) begin
            // Tap k: row k/3 (top = oldest), column n-1, n, n+1 = age 2, 1, 0
            px   = icc_ext9(d_q.win[k / 3][2 - (k % 3)], c_q.setup[ICC_SET_DFMT]); // R19 R24
            cf   = icc_ext9(c_q.coef[c_q.bank_sel][k], c_q.setup[ICC_SET_CFMT]);
            prod = px * cf;
            acc  = acc + {{6{prod[17]}}, prod};
        end
        casc_sh = icc_casc_shift(cascade_in, c_q.setup[ICC_SET_SHIFT +: 2]); // R03 R04
        // Cascade word is added only when it is not carrying pixel rows
        total = c_q.setup[ICC_SET_CASC] ? acc : acc + casc_sh; // R01 R05
        unique case (c_q.setup[ICC_SET_RND +: 2])
            ICC_RND_16: rounded = (total + 24'h000008) & 24'hfffff0;
            ICC_RND_8:  rounded = (total + 24'h000800) & 24'hfff000;
            default:    rounded = total; // Code 11 is not valid; treated as none
        endcase
    end

    // Datapath next state; everything frozen while hold is in effect
    always_comb begin
        logic [7:0] top_px;
        logic [7:0] mid_px;
        d_d = d_q;
        // External rows come from the cascade word in cascade mode
        top_px = c_q.setup[ICC_SET_CASC] ? cascade_in[15:8] : row2; // R02
        mid_px = c_q.setup[ICC_SET_CASC] ? cascade_in[7:0]  : row1; // R02
        if (run) begin // R09
            d_d.dly[0] = pixel_in;
            d_d.dly[1] = d_q.dly[0];
            d_d.dly[2] = d_q.dly[1];
            // Pointer wraps at the current row length, also when it shrinks
            if ({1'b0, d_q.ptr} >= row_eff - 11'h001) begin // R15 R23
                d_d.ptr = 10'h000;
            end else begin
                d_d.ptr = d_q.ptr + 10'h001;
            end
            if (d_q.fill != ICC_FILL_MAX) begin
                d_d.fill = d_q.fill + 12'h001;
            end
            // Latches shift one column per pixel; age 0 is column n+1
            for (int r = 0; r < 3; r++) begin
                d_d.win[r][2] = d_q.win[r][1];
                d_d.win[r][1] = d_q.win[r][0];
            end
            d_d.win[0][0] = top_px;
            d_d.win[1][0] = mid_px;
            d_d.win[2][0] = bot_px;
            d_d.result    = rounded[19:0]; // R05 R19
        end
    end

    assign result_out = d_q.result;

    // Control next state: bus slave, coefficient loading, row length window
    always_comb begin
        c_d        = c_q;
        c_d.hold_q = hold; // R08
        c_d.ack    = (avs_read | avs_write) & ~c_q.ack;
        // Load window counts from reset release only; frame clear does not touch it
        if (c_q.win_cnt != ICC_LOAD_WINDOW) begin // R26
            c_d.win_cnt = c_q.win_cnt + 11'h001;
            if (c_d.win_cnt == ICC_LOAD_WINDOW) begin
                c_d.row_len = ICC_ROWLEN_RST; // R13
            end
        end
        // Read data are captured in the waiting cycle and stand in the answer cycle
        if (avs_read && !c_q.ack) begin
            c_d.rdata = 32'h00000000;
            unique case (bus_idx)
                ICC_IDX_ROWLEN: c_d.rdata = {22'h000000, c_q.row_len};
                ICC_IDX_SETUP:  c_d.rdata = {23'h000000, c_q.setup};
                ICC_IDX_STATUS: begin
                    c_d.rdata[ICC_ST_CPTR +: 4] = c_q.cptr;
                    c_d.rdata[ICC_ST_BANK]      = c_q.bank_sel;
                    c_d.rdata[ICC_ST_WINDOW]    = (c_q.win_cnt != ICC_LOAD_WINDOW);
                    c_d.rdata[ICC_ST_LOADED]    = c_q.row_lock;
                end
                default: c_d.rdata = 32'h00000000; // Write-only and unmapped read zero
            endcase
        end
        if (wr_fire && wr_lane) begin
            // Leaving the coefficient addresses restarts the A..I sequence
            if (bus_idx != ICC_IDX_COEF0 && bus_idx != ICC_IDX_COEF1) begin
                c_d.cptr = 4'h0;
            end
            unique case (bus_idx) // R22
                ICC_IDX_ROWLEN: begin
                    // Only one load per reset, and only inside the window
                    if (c_q.win_cnt != ICC_LOAD_WINDOW && !c_q.row_lock) begin // R13 R14
                        c_d.row_len  = avs_writedata[9:0];
                        c_d.row_lock = 1'b1;
                    end
                end
                ICC_IDX_COEF0, ICC_IDX_COEF1: begin
                    c_d.coef[bus_idx[0]][c_q.cptr] = avs_writedata[7:0]; // R20
                    c_d.cptr = (c_q.cptr == ICC_NUM_TAPS - 4'h1) ? 4'h0 : c_q.cptr + 4'h1;
                end
                ICC_IDX_SETUP: c_d.setup = avs_writedata[ICC_SETUP_W-1:0]; // R25
                ICC_IDX_SEL0:  c_d.bank_sel = 1'b0; // R21
                ICC_IDX_SEL1:  c_d.bank_sel = 1'b1; // R21
                default: ; // ALU microcode, no-op and unmapped words are ignored
            endcase
        end
    end

    // Control registers: full reset only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin // R10 R11 R12
            c_q          <= '0;
            c_q.row_len  <= ICC_ROWLEN_RST;
            c_q.setup    <= ICC_SETUP_RST;
        end else begin
            c_q <= c_d;
        end
    end

    // Datapath registers: full reset or frame clear, held clear while either is low
    always_ff @(posedge clk or negedge dp_rst_n) begin
        if (!dp_rst_n) begin // R10 R16 R17
            d_q <= '0;
        end else begin
            d_q <= d_d;
        end
    end
endmodule

// ---- verif/icc_convolver_props.sv ----
// Purpose: Concurrent checks on the convolver ports
// Assumes: Bound to icc_convolver; a single clock domain
// Notes:   Load window age kept by a local counter that frame clear leaves alone
`timescale 1ns/1ps
module icc_convolver_props (
    // Clock and resets
    input wire logic                           clk,
    input wire logic                           nrst,
    input wire logic                           frame_n,
    // Stream side
    input wire logic                           hold,
    input wire logic [7:0]                     delayed_pixel_out,
    input wire logic [19:0]                    result_out,
    // Register bus
    input wire logic [icc_pkg::ICC_ADDR_W-1:0] avs_address,
    input wire logic                           avs_read,
    input wire logic                           avs_write,
    input wire logic [31:0]                    avs_readdata,
    input wire logic                           avs_waitrequest
);
    import icc_pkg::*;
    logic [11:0] up_q; // Edges since full reset release, saturating
    logic        rdk;  // Read answered in this cycle
    logic [3:0]  ix;   // Word index of the request
    assign rdk = avs_read & ~avs_waitrequest;
    assign ix  = avs_address[5:2];
    // Margins around 1024 keep the window checks clear of off-by-one doubt
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            up_q <= 12'h000;
        else if (up_q != 12'hfff)
            up_q <= up_q + 12'h001;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    reset_zero_a: assert property (
        $rose(nrst) |-> !(|{result_out, delayed_pixel_out, avs_readdata}))
        else $error("outputs not low after reset");
    frame_clear_a: assert property (
        !frame_n |-> result_out == 20'h0 && delayed_pixel_out == 8'h00)
        else $error("frame clear left datapath output");
    frame_stay_a: assert property (
        $fell(frame_n) |=> (result_out == 20'h0) [*2])
        else $error("result moved during frame clear");
    hold_keep_a: assert property (
        hold ##1 frame_n |=> $stable(result_out) && $stable(delayed_pixel_out))
        else $error("outputs moved in held cycle");
    wait_one_a: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    wait_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest without request");
    unmapped_zero_a: assert property (rdk && ix > 4'h8 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    load_only_zero_a: assert property (
        rdk && ix inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7} |-> avs_readdata == 32'h0)
        else $error("load-only index read not zero");
    window_open_a: assert property (
        rdk && ix == 4'h8 && up_q < 12'h3e8 |-> avs_readdata[5])
        else $error("load window closed early");
    window_shut_a: assert property (
        rdk && ix == 4'h8 && up_q > 12'h44c |-> !avs_readdata[5])
        else $error("load window still open");
    rowlen_forced_a: assert property (
        rdk && ix == 4'h0 && up_q > 12'h44c |-> avs_readdata[9:0] == 10'h000)
        else $error("row length not forced to zero");
    // Main scenarios reached
    cover property (hold ##1 frame_n);
    cover property ($fell(frame_n));
    cover property (rdk && ix > 4'h8);
    cover property (rdk && up_q > 12'h44c);
endmodule

// ---- verif/icc_pix_src.sv ----
// Purpose: Pixel and cascade source standing in front of the convolver
// Assumes: Same clock as the convolver; restarts at pixel 0 whenever run is low
// Notes:   Pauses with hold for two cycles eight pixels into each run
`timescale 1ns/1ps
module icc_pix_src (
    // Clock and control
    input  wire logic        clk,
    input  wire logic        run,
    input  wire logic        cmode,
    // Stream toward the convolver
    output logic      [7:0]  pixel_in,
    output logic      [15:0] cascade_in,
    output logic             hold
);
    logic [11:0] k_q; // Index of the pixel on offer
    // One pixel per edge while running; a paused source keeps advancing
    always_ff @(posedge clk) begin
        if (!run)
            k_q <= 12'h000;
        else
            k_q <= k_q + 12'h001;
    end
    // Raster order from the first pixel, value changing every pixel
    assign pixel_in = k_q[7:0] * 8'h25 + 8'h05;
    // Words change just after an edge, so they are stable around the next one
    assign cascade_in = cmode ? {k_q[7:0] * 8'h0b, k_q[7:0] + 8'h02} : 16'h0100 + {4'h0, k_q};
    assign hold = (k_q == 12'h008) || (k_q == 12'h009);
endmodule

// ---- verif/icc_convolver_tb.sv ----
// Purpose: Self-checking bench for the convolver cascade and control block
// Assumes: Source model drives the stream; the bench is the Avalon-MM host
// Notes:   Expected results come from a log of the pixels the block took
`timescale 1ns/1ps
module icc_convolver_tb;
    import icc_pkg::*;
    logic                  clk, nrst, frame_n, run, cm, hold, avs_read, avs_write;
    logic                  avs_waitrequest;
    logic [7:0]            pixel_in, delayed_pixel_out;
    logic [15:0]           cascade_in;
    logic [19:0]           result_out;
    logic [ICC_ADDR_W-1:0] avs_address;
    logic [3:0]            avs_byteenable;
    logic [31:0]           avs_writedata, avs_readdata, q;
    logic [7:0]            plog [0:2199];   // Pixels taken, oldest first
    logic [15:0]           clog [0:2199];   // Cascade words taken
    logic [7:0]            kern [0:1][0:8]; // Coefficients per bank, A first
    int                    n_errors, checked;
    icc_convolver DUT (.clk(clk), .nrst(nrst), .frame_n(frame_n), .pixel_in(pixel_in),
        .hold(hold), .cascade_in(cascade_in), .delayed_pixel_out(delayed_pixel_out),
        .result_out(result_out), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    icc_pix_src u_src (.clk(clk), .run(run), .cmode(cm), .pixel_in(pixel_in),
        .cascade_in(cascade_in), .hold(hold));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Samples before the frame start read as zero, like the masked buffers
    function automatic logic [7:0] px(input int i);
        return (i < 0) ? 8'h00 : plog[i];
    endfunction
    function automatic logic [15:0] cg(input int i);
        return (i < 0) ? 16'h0000 : clog[i];
    endfunction
    // Nine products over c taken pixels; column j has age 2-j
    function automatic logic [23:0] conv(input int c, input int L, input logic m, input int b);
        logic [23:0] s;
        s = 24'h0;
        for (int j = 0; j < 3; j++) begin
            s += kern[b][j] * (m ? cg(c - 3 + j) >> 8 : px(c - 3 + j - 2 * L));
            s += kern[b][3 + j] * (m ? cg(c - 3 + j) & 16'h00ff : px(c - 3 + j - L));
            s += kern[b][6 + j] * px(c - 3 + j);
        end
        return s;
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // One Avalon transfer; read data taken in the cycle waitrequest is low
    task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] wd,
                       output logic [31:0] rq);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_read <= rd;
        avs_write <= !rd;
        avs_writedata <= wd;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        if (n >= 40) begin
            n_errors++;
            complete_run();
        end
        rq = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b0, a, d, r);
    endtask
    task automatic rdc(input string w, input logic [5:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b1, a, 32'h0, r);
        chk(w, r, e);
    endtask
    // Frame clear, then n edges of streaming checked edge by edge
    task automatic stream(input int n, input int L, input logic c, input logic [1:0] sh,
                          input int b);
        int          cnt  = 0;
        logic        held = 1'b0;
        logic [23:0] e    = 24'h0;
        cm <= c;
        frame_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("cleared result", result_out, 32'h0);
        @(posedge clk);
        frame_n <= 1'b1;
        run <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            if (!held) begin
                e = conv(cnt, L, c, b);
                if (!c)
                    e = e + ({8'h00, cascade_in} << ((sh == 2'b11) ? 8 : 2 * sh));
                plog[cnt] = pixel_in;
                clog[cnt] = cascade_in;
                cnt++;
            end
            held = hold;
            #1 chk("result", result_out, e[19:0]);
            if (!c)
                chk("delayed pixel", delayed_pixel_out, px(cnt - 2 * L));
        end
        run <= 1'b0;
    endtask
    // Main sequence
    initial begin
        {nrst, run, cm, avs_read, avs_write} = 5'h00;
        frame_n = 1'b1;
        avs_address = '0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        n_errors = 0;
        checked = 0;
        repeat (5) @(posedge clk);
        #1 chk("reset outputs", {result_out, delayed_pixel_out}, 32'h0);
        @(posedge clk) nrst <= 1'b1;
        rdc("setup", 6'h10, 32'h0);
        rdc("row length", 6'h00, 32'h0);
        rdc("status", 6'h20, 32'h20);
        rdc("unmapped", 6'h24, 32'h0);
        rdc("alu", 6'h04, 32'h0);
        wr(6'h00, 32'h3);
        wr(6'h00, 32'h5);
        rdc("row length", 6'h00, 32'h3);
        for (int k = 0; k < 9; k++) begin
            kern[0][k] = 8'(k + 1);
            wr(6'h08, 32'(k + 1));
        end
        rdc("status", 6'h20, 32'h60);
        for (int k = 0; k < 9; k++) begin
            kern[1][k] = 8'(17 - 2 * k);
            wr(6'h0c, 32'(17 - 2 * k));
        end
        for (int s = 0; s < 4; s++) begin
            wr(6'h10, 32'(s << 7));
            stream(24, 3, 1'b0, s[1:0], 0);
        end
        wr(6'h10, 32'h1);
        stream(24, 3, 1'b1, 2'b00, 0);
        wr(6'h18, 32'h0);
        wr(6'h10, 32'h0);
        stream(24, 3, 1'b0, 2'b00, 1);
        rdc("status", 6'h20, 32'h70);
        rdc("row length", 6'h00, 32'h3);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        for (int k = 0; k < 9; k++)
            kern[0][k] = 8'h00;
        rdc("status", 6'h20, 32'h20);
        stream(2100, 1024, 1'b0, 2'b00, 0);
        wr(6'h00, 32'h5);
        rdc("row length", 6'h00, 32'h0);
        bus(1'b1, 6'h20, 32'h0, q);
        chk("window", {31'h0, q[5]}, 32'h0);
        complete_run();
    end
endmodule
bind icc_convolver icc_convolver_props u_props (.clk(clk), .nrst(nrst), .frame_n(frame_n),
    .hold(hold), .delayed_pixel_out(delayed_pixel_out), .result_out(result_out),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
